/* File: cpu_core_model.sv */
// cpu_core_model: far-side cpu core taking requests and fetching vectors.
// assumes the bench drives ack_en as the software mask clear and rti.
`timescale 1ns/100ps
module cpu_core_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cpu_irq,
   input wire logic [15:0] irq_vector,
   input wire logic ack_en,
   input wire logic rti,
   output logic cpu_int_mask,
   output logic [15:0] taken_vec
);
   logic in_svc_q;
   // mask set in reset and while a routine runs, so no nesting
   assign cpu_int_mask = rst | ~ack_en | in_svc_q;
   // set mask, latch vector; rti ends service
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         in_svc_q <= 1'b0;
         taken_vec <= 16'h0000;
      end else if (rti) begin
         in_svc_q <= 1'b0;
         taken_vec <= 16'h0000;
      end else if (cpu_irq && !cpu_int_mask) begin
         in_svc_q <= 1'b1;
         taken_vec <= irq_vector;
      end
   end
endmodule : cpu_core_model

/* File: fall_edge_flag.sv */
// fall_edge_flag: one sticky flag set by a falling edge of a synchronous
// input, cleared by a one-cycle clear strobe.
// assumes the input is already synchronous to core_clk.
`timescale 1ns/100ps
module fall_edge_flag (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sense,
   input wire logic arm,
   input wire logic clear,
   output logic flag_q
);

   logic prev_q;
   logic fall;

   // previous level resets to the idle high, so a pin found low after reset counts as a fall
   assign fall = prev_q & ~sense & arm;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prev_q <= 1'b1;
      end else begin
         prev_q <= sense;
      end
   end

   // set beats clear so an edge during the clear write survives
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else if (fall) begin
         flag_q <= 1'b1;
      end else if (clear) begin
         flag_q <= 1'b0;
      end
   end

endmodule : fall_edge_flag

/* File: irq_flag_vector.sv */
// irq_flag_vector: interrupt flag status register, enables, request
// qualification by the cpu mask and fixed-priority vector selection.
// assumes pins and peripheral requests are synchronous to core_clk and the
// cpu core supplies its mask bit as a level.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - a falling edge on the external interrupt pin sets the external flag in bit 7.
// - the external interrupt is requested only with its enable and flag set and mask clear.
// - the external flag is read-only and writing one to bit 3 clears it, zero does nothing.
// - the external flag clear bit is write-only and reads as zero.
// - a falling edge on an enabled key wake-up input sets the key flag in bit 4.
// - the key interrupt is requested while its enable and its flag are both set.
// - writing one to bit 0 clears the key flag, zero does nothing, the flag is not writable.
// - the key flag clear bit is write-only and reads as zero.
// - bits 6:5 and 2:1 of the flag status register ignore writes and read zero.
// - reset clears both flags so the flag status register reads zero.
// - the pulse-width interrupt needs its enable and a clear mask and uses vector 1FF6.
// - the serial interrupt needs its enable and a clear mask and uses vector 1FF2.
// - the event counter interrupt needs a clear mask and uses vector 1FF4.
// - the time-base interrupt needs a clear mask and uses vector 1FF0.
// - the key wake-up interrupt needs a clear mask and uses vector 1FF8.
// - among pending sources the one with the highest vector address is served first.
module irq_flag_vector
   import irq_pkg::*;
#(
   parameter int KEYS = NUM_KEYS
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic ext_irq_pin,
   input wire logic [KEYS-1:0] key_wake_pin,
   input wire logic pulse_width_interrupt,
   input wire logic serial_interrupt,
   input wire logic event_count_interrupt,
   input wire logic time_base_interrupt,
   input wire logic cpu_int_mask,
   output logic cpu_irq,
   output logic [15:0] irq_vector,
   output logic irq_status_int
);

   ////////////////////////////////////////////////////////////////////////////
   // register state

   logic ext_int_enable_q;
   logic key_wake_int_enable_q;
   logic [KEYS-1:0] key_input_enable_q;
   logic pulse_width_int_enable_q;
   logic serial_int_enable_q;
   logic [NUM_EVENTS-1:0] event_status_q;
   logic [NUM_EVENTS-1:0] event_status_d;
   logic [NUM_EVENTS-1:0] event_mask_q;
   logic [15:0] irq_vector_q;
   logic [15:0] irq_vector_d;
   logic cpu_irq_q;
   logic irq_status_int_q;
   logic [DATA_W-1:0] reg_rdata_q;
   logic [DATA_W-1:0] reg_rdata_d;

   logic ext_irq_flag;
   logic key_wake_flag;
   logic [KEYS-1:0] key_latch;

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   logic wr_status;
   logic wr_ctrl;
   logic wr_keyen;
   logic wr_srcen;
   logic wr_evstat;
   logic wr_evmask;

   assign wr_status = reg_wr && (reg_addr == INTERRUPT_FLAG_STATUS_ADDR);
   assign wr_ctrl = reg_wr && (reg_addr == INT_CONTROL_ADDR);
   assign wr_keyen = reg_wr && (reg_addr == KEY_ENABLE_ADDR);
   assign wr_srcen = reg_wr && (reg_addr == SOURCE_ENABLE_ADDR);
   assign wr_evstat = reg_wr && (reg_addr == EVENT_STATUS_ADDR);
   assign wr_evmask = reg_wr && (reg_addr == EVENT_MASK_ADDR);

   // clear strobes only; writes never set a flag
   logic ext_flag_clear;
   logic key_wake_flag_clear;

   assign ext_flag_clear = wr_status & reg_wdata[EXT_CLEAR_BIT];
   assign key_wake_flag_clear = wr_status & reg_wdata[KEY_CLEAR_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // edge flags

   // external pin flag; arm is always on
   fall_edge_flag u_ext_flag (
      .core_clk(core_clk),
      .rst(rst),
      .sense(ext_irq_pin),
      .arm(1'b1),
      .clear(ext_flag_clear),
      .flag_q(ext_irq_flag)
   );

   // one latch per key input, all cleared together with the key flag
   genvar k;
   generate
      for (k = 0; k < KEYS; k++) begin : g_key
         fall_edge_flag u_key_flag (
            .core_clk(core_clk),
            .rst(rst),
            .sense(key_wake_pin[k]),
            .arm(key_input_enable_q[k]),
            .clear(key_wake_flag_clear),
            .flag_q(key_latch[k])
         );
      end
   endgenerate

   assign key_wake_flag = |key_latch;

   ////////////////////////////////////////////////////////////////////////////
   // request qualification

   logic req_ext;
   logic req_key;
   logic req_pulse;
   logic req_event;
   logic req_serial;
   logic req_time;
   logic unmasked;

   assign unmasked = ~cpu_int_mask;
   assign req_ext = ext_int_enable_q & ext_irq_flag & unmasked;
   // the key request exists regardless of the mask; the mask gates taking it
   assign req_key = key_wake_int_enable_q & key_wake_flag;
   assign req_pulse = pulse_width_int_enable_q & pulse_width_interrupt & unmasked;
   assign req_serial = serial_int_enable_q & serial_interrupt & unmasked;
   assign req_event = event_count_interrupt & unmasked;
   assign req_time = time_base_interrupt & unmasked;

   logic take_key;
   assign take_key = req_key & unmasked;

   ////////////////////////////////////////////////////////////////////////////
   // vector selection, highest vector address wins

   assign irq_vector_d = req_ext ? VEC_EXT :
                         take_key ? VEC_KEY :
                         req_pulse ? VEC_PULSE :
                         req_event ? VEC_EVENT :
                         req_serial ? VEC_SERIAL :
                         req_time ? VEC_TIME :
                         VEC_NONE;

   logic any_req;
   assign any_req = req_ext | take_key | req_pulse | req_event | req_serial | req_time;

   ////////////////////////////////////////////////////////////////////////////
   // sticky event status, write one to clear, set wins

   logic [NUM_EVENTS-1:0] ev_set;
   logic [NUM_EVENTS-1:0] ev_clr;

   assign ev_set = {req_time, req_serial, req_event, req_pulse, req_key, req_ext};
   assign ev_clr = wr_evstat ? reg_wdata[NUM_EVENTS-1:0] : '0;
   assign event_status_d = ev_set | (event_status_q & ~ev_clr);

   ////////////////////////////////////////////////////////////////////////////
   // read mux; write-only clear bits and unused bits read zero

   logic [DATA_W-1:0] status_view;

   always_comb begin
      status_view = REG_RESET;
      status_view[EXT_FLAG_BIT] = ext_irq_flag;
      status_view[KEY_FLAG_BIT] = key_wake_flag;
   end

   always_comb begin
      reg_rdata_d = REG_RESET;
      if (reg_rd) begin
         unique case (reg_addr)
            INTERRUPT_FLAG_STATUS_ADDR: begin
               reg_rdata_d = status_view;
            end
            INT_CONTROL_ADDR: begin
               reg_rdata_d[EXT_ENABLE_BIT] = ext_int_enable_q;
               reg_rdata_d[KEY_INT_ENABLE_BIT] = key_wake_int_enable_q;
            end
            KEY_ENABLE_ADDR: begin
               reg_rdata_d[KEYS-1:0] = key_input_enable_q;
            end
            SOURCE_ENABLE_ADDR: begin
               reg_rdata_d[PULSE_ENABLE_BIT] = pulse_width_int_enable_q;
               reg_rdata_d[SERIAL_ENABLE_BIT] = serial_int_enable_q;
            end
            EVENT_STATUS_ADDR: begin
               reg_rdata_d[NUM_EVENTS-1:0] = event_status_q;
            end
            EVENT_MASK_ADDR: begin
               reg_rdata_d[NUM_EVENTS-1:0] = event_mask_q;
            end
            VECTOR_ADDR_HI: begin
               reg_rdata_d = irq_vector_q[15:8];
            end
            VECTOR_ADDR_LO: begin
               reg_rdata_d = irq_vector_q[7:0];
            end
            default: begin
               reg_rdata_d = REG_RESET; // unmapped reads zero
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ext_int_enable_q <= 1'b0;
         key_wake_int_enable_q <= 1'b0;
      end else if (wr_ctrl) begin
         ext_int_enable_q <= reg_wdata[EXT_ENABLE_BIT];
         key_wake_int_enable_q <= reg_wdata[KEY_INT_ENABLE_BIT];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         key_input_enable_q <= '0;
      end else if (wr_keyen) begin
         key_input_enable_q <= reg_wdata[KEYS-1:0];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pulse_width_int_enable_q <= 1'b0;
         serial_int_enable_q <= 1'b0;
      end else if (wr_srcen) begin
         pulse_width_int_enable_q <= reg_wdata[PULSE_ENABLE_BIT];
         serial_int_enable_q <= reg_wdata[SERIAL_ENABLE_BIT];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         event_mask_q <= '0;
      end else if (wr_evmask) begin
         event_mask_q <= reg_wdata[NUM_EVENTS-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all registered

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         event_status_q <= '0;
         irq_vector_q <= VEC_NONE;
         cpu_irq_q <= 1'b0;
         irq_status_int_q <= 1'b0;
         reg_rdata_q <= REG_RESET;
      end else begin
         event_status_q <= event_status_d;
         irq_vector_q <= irq_vector_d;
         cpu_irq_q <= any_req;
         irq_status_int_q <= |(event_status_d & event_mask_q);
         reg_rdata_q <= reg_rdata_d;
      end
   end

   assign reg_rdata = reg_rdata_q;
   assign irq_vector = irq_vector_q;
   assign cpu_irq = cpu_irq_q;
   assign irq_status_int = irq_status_int_q;

endmodule : irq_flag_vector

/* File: irq_flag_vector_properties.sv */
// irq_flag_vector_properties: port checks of irq_flag_vector.
// assumes core_clk with active-high async rst; bound below.
`timescale 1ns/100ps
module irq_flag_vector_properties
   import irq_pkg::*;
#(
   parameter int KEYS = NUM_KEYS
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic ext_irq_pin,
   input wire logic [KEYS-1:0] key_wake_pin,
   input wire logic pulse_width_interrupt,
   input wire logic serial_interrupt,
   input wire logic event_count_interrupt,
   input wire logic time_base_interrupt,
   input wire logic cpu_int_mask,
   input wire logic cpu_irq,
   input wire logic [15:0] irq_vector,
   input wire logic irq_status_int
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire logic st_rd = reg_rd && reg_addr == INTERRUPT_FLAG_STATUS_ADDR;

   ////////////////////////////////////////////////////////////////////////
   // requests against the mask and the vector
   chk_mask_blocks: assert property (cpu_int_mask |=> !cpu_irq)
      else $error("request passed a set mask");
   chk_vec_pairs: assert property (cpu_irq == (irq_vector != VEC_NONE))
      else $error("request and vector disagree");
   chk_time_taken: assert property (!cpu_int_mask && time_base_interrupt |=> cpu_irq)
      else $error("time base request lost");
   chk_event_rank: assert property (!cpu_int_mask && event_count_interrupt |=>
      irq_vector >= VEC_EVENT) else $error("event vector outranked");
   chk_pulse_cause: assert property (irq_vector == VEC_PULSE |->
      $past(pulse_width_interrupt) && !$past(cpu_int_mask)) else $error("pulse vector uncaused");
   chk_serial_rank: assert property (irq_vector == VEC_SERIAL |->
      $past(serial_interrupt) && !$past(event_count_interrupt)) else $error("serial vector wrong");

   ////////////////////////////////////////////////////////////////////////
   // register port
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
   chk_status_zero: assert property (st_rd |=> (reg_rdata & 8'h6F) == 8'h00)
      else $error("status spare bit set");
   chk_ext_edge: assert property ($fell(ext_irq_pin) ##1 st_rd |=> reg_rdata[7])
      else $error("falling edge not flagged");
   chk_reset_quiet: assert property ($fell(rst) |-> !cpu_irq && !irq_status_int)
      else $error("outputs active after reset");

   cover property (cpu_irq && irq_vector == VEC_EXT);
   cover property (irq_vector == VEC_KEY);
   cover property (irq_status_int);
   cover property ($fell(ext_irq_pin) && reg_wr);
endmodule : irq_flag_vector_properties

bind irq_flag_vector irq_flag_vector_properties #(.KEYS(KEYS)) i_irq_flag_vector_properties (
   .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_pin(ext_irq_pin),
   .key_wake_pin(key_wake_pin), .pulse_width_interrupt(pulse_width_interrupt),
   .serial_interrupt(serial_interrupt), .event_count_interrupt(event_count_interrupt),
   .time_base_interrupt(time_base_interrupt), .cpu_int_mask(cpu_int_mask),
   .cpu_irq(cpu_irq), .irq_vector(irq_vector), .irq_status_int(irq_status_int));

/* File: irq_pkg.sv */
// irq_pkg: register map, field positions, reset values and vectors of the
// interrupt flag and vector logic.
// assumes an 8-bit register port with a 16-bit address space.
package irq_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int NUM_KEYS = 4;

   // documented register
   localparam logic [15:0] INTERRUPT_FLAG_STATUS_ADDR = 16'h0009;
   // gathered control and status registers
   localparam logic [15:0] INT_CONTROL_ADDR = 16'h0008;
   localparam logic [15:0] KEY_ENABLE_ADDR = 16'h0040;
   localparam logic [15:0] SOURCE_ENABLE_ADDR = 16'h0041;
   localparam logic [15:0] EVENT_STATUS_ADDR = 16'h0042;
   localparam logic [15:0] EVENT_MASK_ADDR = 16'h0043;
   localparam logic [15:0] VECTOR_ADDR_HI = 16'h0044;
   localparam logic [15:0] VECTOR_ADDR_LO = 16'h0045;

   // flag status bit positions
   localparam int EXT_FLAG_BIT = 7;
   localparam int KEY_FLAG_BIT = 4;
   localparam int EXT_CLEAR_BIT = 3;
   localparam int KEY_CLEAR_BIT = 0;

   // control register bit positions
   localparam int EXT_ENABLE_BIT = 7;
   localparam int KEY_INT_ENABLE_BIT = 4;

   // source enable register bit positions
   localparam int PULSE_ENABLE_BIT = 0;
   localparam int SERIAL_ENABLE_BIT = 1;

   // event status bits: source pending seen on the flag/request side
   localparam int EV_EXT = 0;
   localparam int EV_KEY = 1;
   localparam int EV_PULSE = 2;
   localparam int EV_EVENT = 3;
   localparam int EV_SERIAL = 4;
   localparam int EV_TIME = 5;
   localparam int NUM_EVENTS = 6;

   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [15:0] VEC_EXT = 16'h1FFA;
   localparam logic [15:0] VEC_KEY = 16'h1FF8;
   localparam logic [15:0] VEC_PULSE = 16'h1FF6;
   localparam logic [15:0] VEC_EVENT = 16'h1FF4;
   localparam logic [15:0] VEC_SERIAL = 16'h1FF2;
   localparam logic [15:0] VEC_TIME = 16'h1FF0;
   localparam logic [15:0] VEC_NONE = 16'h0000;

endpackage : irq_pkg

/* File: tb_irq_flag_vector.sv */
// tb_irq_flag_vector: self-checking bench of irq_flag_vector.
// assumes cpu_core_model on the far side and the bound checker.
`timescale 1ns/100ps
module tb_irq_flag_vector;
   import irq_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic ext_irq_pin = 1'b1;
   logic [3:0] key_wake_pin = 4'hF;
   logic [3:0] periph = 4'h0; // pulse, serial, event, time
   logic ack_en = 1'b0;
   logic rti = 1'b0;
   logic [7:0] reg_rdata;
   logic cpu_int_mask, cpu_irq, irq_status_int;
   logic [15:0] irq_vector, taken_vec;
   int err_total = 0;
   int n_tests = 0;
   // rows: mask released, pulse/serial/event/time levels, vector taken
   logic [20:0] rows [9] = '{21'h181FF6, 21'h141FF2, 21'h121FF4, 21'h111FF0,
      21'h1F1FF6, 21'h171FF4, 21'h151FF2, 21'h0F0000, 21'h100000};

   always #20 core_clk = ~core_clk;

   irq_flag_vector #(.KEYS(4)) i_irq_flag_vector (.core_clk(core_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ext_irq_pin(ext_irq_pin), .key_wake_pin(key_wake_pin),
      .pulse_width_interrupt(periph[3]), .serial_interrupt(periph[2]),
      .event_count_interrupt(periph[1]), .time_base_interrupt(periph[0]),
      .cpu_int_mask(cpu_int_mask), .cpu_irq(cpu_irq), .irq_vector(irq_vector),
      .irq_status_int(irq_status_int));
   cpu_core_model i_cpu_core_model (.core_clk(core_clk), .rst(rst), .cpu_irq(cpu_irq),
      .irq_vector(irq_vector), .ack_en(ack_en), .rti(rti), .cpu_int_mask(cpu_int_mask),
      .taken_vec(taken_vec));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // data stand only in the cycle after the read edge
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, e});
   endtask : rd
   // release the mask, let the core take a request, then return
   task automatic serve(input logic en, input logic [15:0] e);
      @(posedge core_clk);
      ack_en <= en;
      repeat (4) @(posedge core_clk);
      ack_en <= 1'b0;
      #1 chk("taken_vec", taken_vec, e);
      @(posedge core_clk);
      rti <= 1'b1;
      @(posedge core_clk);
      rti <= 1'b0;
   endtask : serve
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////////////
   // whole run is well under 1000 cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      err_total++;
      $display("watchdog expired");
      stop_test();
   end

   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      rd(INTERRUPT_FLAG_STATUS_ADDR, 8'h00);
      rd(16'h0100, 8'h00);
      $display("reset test done");
      wr(SOURCE_ENABLE_ADDR, 8'h03);
      foreach (rows[i]) begin
         periph <= rows[i][19:16];
         serve(rows[i][20], rows[i][15:0]);
      end
      wr(SOURCE_ENABLE_ADDR, 8'h00);
      periph <= 4'hC;
      serve(1'b1, VEC_NONE);
      periph <= 4'h0;
      $display("vector table done");
      // external flag: set, zero writes, serve, clear
      wr(EVENT_MASK_ADDR, 8'h01);
      wr(INT_CONTROL_ADDR, 8'h80);
      ext_irq_pin <= 1'b0;
      rd(INTERRUPT_FLAG_STATUS_ADDR, 8'h80);
      wr(INTERRUPT_FLAG_STATUS_ADDR, 8'h76);
      rd(INTERRUPT_FLAG_STATUS_ADDR, 8'h80);
      serve(1'b1, VEC_EXT);
      chk("irq_status_int", {15'h0000, irq_status_int}, 16'h0001);
      rd(EVENT_STATUS_ADDR, 8'h3D);
      wr(INTERRUPT_FLAG_STATUS_ADDR, 8'h08);
      rd(INTERRUPT_FLAG_STATUS_ADDR, 8'h00);
      // edge lands in the clearing write's cycle
      @(posedge core_clk);
      ext_irq_pin <= 1'b1;
      @(posedge core_clk);
      reg_addr <= INTERRUPT_FLAG_STATUS_ADDR;
      reg_wdata <= 8'h08;
      reg_wr <= 1'b1;
      ext_irq_pin <= 1'b0;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      rd(INTERRUPT_FLAG_STATUS_ADDR, 8'h80);
      $display("external flag done");
      // key inputs: disabled one ignored, enabled one flags
      wr(KEY_ENABLE_ADDR, 8'h01);
      key_wake_pin <= 4'hD;
      rd(INTERRUPT_FLAG_STATUS_ADDR, 8'h80);
      @(posedge core_clk);
      key_wake_pin <= 4'hC;
      rd(INTERRUPT_FLAG_STATUS_ADDR, 8'h90);
      wr(INT_CONTROL_ADDR, 8'h90);
      rd(INT_CONTROL_ADDR, 8'h90);
      rd(KEY_ENABLE_ADDR, 8'h01);
      serve(1'b1, VEC_EXT);
      wr(INTERRUPT_FLAG_STATUS_ADDR, 8'h08);
      serve(1'b1, VEC_KEY);
      wr(INTERRUPT_FLAG_STATUS_ADDR, 8'h01);
      rd(INTERRUPT_FLAG_STATUS_ADDR, 8'h00);
      wr(EVENT_STATUS_ADDR, 8'h3F);
      repeat (2) @(posedge core_clk);
      chk("irq_status_int", {15'h0000, irq_status_int}, 16'h0000);
      rd(EVENT_STATUS_ADDR, 8'h00);
      $display("key flag done");
      // second reset with the external flag set, pin idle high through it
      wr(INT_CONTROL_ADDR, 8'h00);
      ext_irq_pin <= 1'b1;
      @(posedge core_clk);
      ext_irq_pin <= 1'b0;
      rd(INTERRUPT_FLAG_STATUS_ADDR, 8'h80);
      @(posedge core_clk);
      rst <= 1'b1;
      ext_irq_pin <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      rd(INTERRUPT_FLAG_STATUS_ADDR, 8'h00);
      $display("second reset done");
      stop_test();
   end
endmodule : tb_irq_flag_vector
